// ---- rtl/gpc_pkg.sv ----
// constants shared by the pin control block and its input filter
package gpc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [15:0] PIN5_IDX   = 16'h403C;
   localparam logic [15:0] PIN6_IDX   = 16'h403D;
   localparam logic [15:0] LEVEL_IDX  = 16'h4040;
   localparam logic [13:0] ADDR_TOP   = 14'h0000;
   localparam logic [2:0]  SIZE_WORD  = 3'h2;

   ////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int unsigned DIR_BIT    = 15;
   localparam int unsigned PULL_HI    = 14;
   localparam int unsigned PULL_LO    = 13;
   localparam int unsigned MODE_BIT   = 12;
   localparam int unsigned SUPPLY_BIT = 11;
   localparam int unsigned POL_BIT    = 10;
   localparam int unsigned OD_BIT     = 9;
   localparam int unsigned ENA_BIT    = 7;
   localparam int unsigned FN_HI      = 3;
   localparam logic [15:0] CTRL_RESET = 16'hA400;
   localparam logic [15:0] CTRL_WMASK = 16'hFE8F;
   localparam logic [1:0]  PULL_DOWN  = 2'h1;
   localparam logic [1:0]  PULL_UP    = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // level register fields
   localparam int unsigned LVL_OUT_LO = 0;
   localparam int unsigned LVL_IN_LO  = 8;

   ////////////////////////////////////////////////////////////////////////
   // function codes
   localparam logic [3:0] FI_LONG        = 4'h0;
   localparam logic [3:0] FI_SLEEP_LONG  = 4'h4;
   localparam logic [3:0] FI_WDOG        = 4'h7;
   localparam logic [3:0] FI_HWCTL1_LONG = 4'hE;
   localparam logic [3:0] FI_HWCTL2_LONG = 4'hF;
   localparam logic [3:0] FO_LEVEL       = 4'h0;
   localparam logic [3:0] FO_RSV_LO      = 4'h5;
   localparam logic [3:0] FO_RSV_HI      = 4'h7;

   ////////////////////////////////////////////////////////////////////////
   // filter timing
   localparam int unsigned CLK_HZ       = 25000000;
   localparam int unsigned DB_NORMAL_US = 1000;
   localparam int unsigned DB_LONG_US   = 20000;
   localparam int unsigned DB_NORMAL_CYC = DB_NORMAL_US * (CLK_HZ / 1000000);
   localparam int unsigned DB_LONG_CYC   = DB_LONG_US * (CLK_HZ / 1000000);
   localparam int unsigned CNT_W         = 20;

endpackage : gpc_pkg

// ---- rtl/gpc_filter.sv ----
// pin input synchroniser and debounce filter
`timescale 1ns/1ps
`default_nettype none

module gpc_filter #(
   parameter int unsigned NORMAL_CYC = gpc_pkg::DB_NORMAL_CYC,
   parameter int unsigned LONG_CYC   = gpc_pkg::DB_LONG_CYC
) (
   input  wire logic ref_clk,   // system clock
   input  wire logic reset,     // synchronous reset, active high
   input  wire logic pad_in,    // raw pin level, asynchronous
   input  wire logic long_sel,  // select the long filter time
   output logic      level      // filtered pin level
);

   localparam logic [gpc_pkg::CNT_W-1:0] NORMAL_M1 =
      gpc_pkg::CNT_W'(NORMAL_CYC - 1);
   localparam logic [gpc_pkg::CNT_W-1:0] LONG_M1 =
      gpc_pkg::CNT_W'(LONG_CYC - 1);

   typedef struct packed {
      logic                      s1;
      logic                      s2;
      logic                      level;
      logic [gpc_pkg::CNT_W-1:0] cnt;
   } gpc_flt_t;

   gpc_flt_t                  st_reg;
   gpc_flt_t                  st_next;
   logic [gpc_pkg::CNT_W-1:0] lim;

   ////////////////////////////////////////////////////////////////////////
   // two-stage sync, then a level must stand a full window to pass
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = pad_in;
      st_next.s2 = st_reg.s1;
      lim        = long_sel ? LONG_M1 : NORMAL_M1;
      if (st_reg.s2 == st_reg.level) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt >= lim) begin
         st_next.level = st_reg.s2;
         st_next.cnt   = '0;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.level;

   ////////////////////////////////////////////////////////////////////////
   // a new level passes only after the count has run out
   a_debounce_len: assert property (@(posedge ref_clk) disable iff (reset)
      $changed(st_reg.level) |-> $past(st_reg.cnt) >= $past(lim))
      else $error("filtered level changed before its window ran out");

endmodule : gpc_filter

`default_nettype wire

// ---- rtl/gpc_top.sv ----
// two general-purpose pin control registers behind an AHB-Lite slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module gpc_top #(
   parameter int unsigned NORMAL_DB_CYC = gpc_pkg::DB_NORMAL_CYC,
   parameter int unsigned LONG_DB_CYC   = gpc_pkg::DB_LONG_CYC
) (
   input  wire logic        ref_clk,                // 25 MHz clock
   input  wire logic        reset,                  // sync reset
   input  wire logic        hsel,                   // slave select
   input  wire logic [31:0] haddr,                  // byte address
   input  wire logic [1:0]  htrans,                 // transfer type
   input  wire logic        hwrite,                 // write when high
   input  wire logic [2:0]  hsize,                  // transfer size
   input  wire logic        hready,                 // bus ready
   input  wire logic [31:0] hwdata,                 // write data
   output logic             hreadyout,              // always ready
   output logic             hresp,                  // always okay
   output logic [31:0]      hrdata,                 // read data
   input  wire logic        pin5_pad_in,            // pin 5 level
   output logic             pin5_pad_out,           // pin 5 drive
   output logic             pin5_pad_oe,            // pin 5 enable
   output logic             pin5_pull_up_en,        // pin 5 pull-up
   output logic             pin5_pull_down_en,      // pin 5 pull-down
   output logic             pin5_supply_select,     // pin 5 supply
   output logic             pin5_edge_event,        // pin 5 edge pulse
   input  wire logic        pin6_pad_in,            // pin 6 level
   output logic             pin6_pad_out,           // pin 6 drive
   output logic             pin6_pad_oe,            // pin 6 enable
   output logic             pin6_pull_up_en,        // pin 6 pull-up
   output logic             pin6_pull_down_en,      // pin 6 pull-down
   output logic             pin6_supply_select,     // pin 6 supply
   output logic             pin6_edge_event,        // pin 6 edge pulse
   input  wire logic        osc_32k_clk,            // 32.768 kHz clock
   input  wire logic        active_state,           // active indication
   input  wire logic        sleep_state,            // sleep indication
   input  wire logic        power_state_change,     // state change
   input  wire logic        vscale_done_1,          // buck 1 done
   input  wire logic        vscale_done_2,          // buck 2 done
   input  wire logic        ext_power_enable_1,     // ext enable 1
   input  wire logic        ext_power_enable_2,     // ext enable 2
   input  wire logic        system_supply_good,     // supply good
   input  wire logic        converter_power_good,   // converters good
   input  wire logic        ext_power_clk_2m,       // 2 MHz clock
   input  wire logic        aux_reset,              // auxiliary reset
   output logic             power_onoff_req,        // on/off request
   output logic             sleep_wake_req,         // sleep/wake request
   output logic             sleep_req,              // sleep request
   output logic             power_on_req,           // power-on request
   output logic             watchdog_reset_req,     // watchdog reset
   output logic             voltage_scale_select_1, // scaling select 1
   output logic             voltage_scale_select_2, // scaling select 2
   output logic             hw_enable_1,            // hardware enable 1
   output logic             hw_enable_2,            // hardware enable 2
   output logic             hw_control_1,           // hardware control 1
   output logic             hw_control_2            // hardware control 2
);

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [1:0][15:0] ctrl;
      logic [1:0]       out_lvl;
      logic [2:0]       wr_hit;
      logic [31:0]      rdata;
      logic [1:0]       pad_out;
      logic [1:0]       pad_oe;
      logic [1:0]       pull_up;
      logic [1:0]       pull_dn;
      logic [1:0]       supply;
      logic [1:0]       prev_lvl;
      logic [1:0]       edge_ev;
      logic [15:0]      fin;
      logic             osc_s1;
      logic             osc_s2;
   } gpc_state_t;

   gpc_state_t  st_reg;
   gpc_state_t  st_next;
   logic [1:0]  flt;
   logic [1:0]  long_sel;
   logic [1:0]  asserted;
   logic [15:0] src;
   logic        acc;
   logic [2:0]  hit;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic reg_hit(input logic [31:0] a,
                                    input logic [15:0] idx);
      reg_hit = (a[31:18] == gpc_pkg::ADDR_TOP) && (a[17:2] == idx);
   endfunction : reg_hit

   function automatic logic is_long(input logic [3:0] fn);
      is_long = (fn == gpc_pkg::FI_LONG) || (fn == gpc_pkg::FI_SLEEP_LONG) ||
                (fn == gpc_pkg::FI_HWCTL1_LONG) ||
                (fn == gpc_pkg::FI_HWCTL2_LONG);
   endfunction : is_long

   ////////////////////////////////////////////////////////////////////////
   // input filters, one per pin
   gpc_filter #(
      .NORMAL_CYC (NORMAL_DB_CYC),
      .LONG_CYC   (LONG_DB_CYC)
   ) u_flt5 (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .pad_in   (pin5_pad_in),
      .long_sel (long_sel[0]),
      .level    (flt[0])
   );

   gpc_filter #(
      .NORMAL_CYC (NORMAL_DB_CYC),
      .LONG_CYC   (LONG_DB_CYC)
   ) u_flt6 (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .pad_in   (pin6_pad_in),
      .long_sel (long_sel[1]),
      .level    (flt[1])
   );

   ////////////////////////////////////////////////////////////////////////
   // output function sources indexed by code; reserved codes read zero, so the pin stays at its inactive level
   assign src = {aux_reset, ext_power_clk_2m,
                 converter_power_good, system_supply_good,
                 ext_power_enable_2, ext_power_enable_1,
                 vscale_done_2, vscale_done_1,
                 3'h0,
                 power_state_change, sleep_state,
                 active_state,
                 st_reg.osc_s2, 1'b0};

   // address phase decode, whole words only
   assign acc = hsel && hready && htrans[1] && (hsize == gpc_pkg::SIZE_WORD);
   assign hit = {reg_hit(haddr, gpc_pkg::LEVEL_IDX),
                 reg_hit(haddr, gpc_pkg::PIN6_IDX),
                 reg_hit(haddr, gpc_pkg::PIN5_IDX)};

   ////////////////////////////////////////////////////////////////////////
   // next state: bus writes, read data, pin control
   always_comb begin
      logic [15:0] c;
      logic        dir_in;
      logic        run;
      logic        pol;
      logic [3:0]  fn;
      logic        v;
      logic        drv;
      c       = '0;
      dir_in  = 1'b0;
      run     = 1'b0;
      pol     = 1'b0;
      fn      = '0;
      v       = 1'b0;
      drv     = 1'b0;
      st_next = st_reg;
      st_next.osc_s1 = osc_32k_clk;
      st_next.osc_s2 = st_reg.osc_s1;
      // data phase of a write
      for (int i = 0; i < 2; i++) begin
         if (st_reg.wr_hit[i]) begin
            st_next.ctrl[i] = hwdata[15:0] & gpc_pkg::CTRL_WMASK;
         end
      end
      if (st_reg.wr_hit[2]) begin
         st_next.out_lvl = hwdata[gpc_pkg::LVL_OUT_LO +: 2];
      end
      st_next.wr_hit = (acc && hwrite) ? hit : 3'h0;
      // per-pin behaviour from the stored control words
      st_next.fin = '0;
      for (int i = 0; i < 2; i++) begin
         c      = st_reg.ctrl[i];
         dir_in = c[gpc_pkg::DIR_BIT];
         run    = c[gpc_pkg::ENA_BIT];
         pol    = c[gpc_pkg::POL_BIT];
         fn     = c[gpc_pkg::FN_HI:0];
         long_sel[i] = dir_in && is_long(fn);
         asserted[i] = pol ? flt[i] : ~flt[i];
         st_next.prev_lvl[i] = flt[i];
         st_next.edge_ev[i]  = dir_in && run && (flt[i] != st_reg.prev_lvl[i])
                               && (c[gpc_pkg::MODE_BIT] || (flt[i] == pol));
         if (dir_in && run) begin
            st_next.fin[fn] = st_next.fin[fn] | asserted[i];
         end
         if (fn == gpc_pkg::FO_LEVEL) begin
            v = st_reg.out_lvl[i];
         end else begin
            v = src[fn];
         end
         drv = pol ? v : ~v;
         st_next.pad_oe[i]  = run && !dir_in &&
                              (!c[gpc_pkg::OD_BIT] || !drv);
         st_next.pad_out[i] = !c[gpc_pkg::OD_BIT] && drv;
         st_next.pull_up[i] =
            (c[gpc_pkg::PULL_HI:gpc_pkg::PULL_LO] == gpc_pkg::PULL_UP);
         st_next.pull_dn[i] =
            (c[gpc_pkg::PULL_HI:gpc_pkg::PULL_LO] == gpc_pkg::PULL_DOWN);
         st_next.supply[i]  = c[gpc_pkg::SUPPLY_BIT];
      end
      // read data for the next data phase, forwarding a pending write
      st_next.rdata = '0;
      if (acc && !hwrite) begin
         if (hit[0]) begin
            st_next.rdata = {16'h0000, st_next.ctrl[0]};
         end else if (hit[1]) begin
            st_next.rdata = {16'h0000, st_next.ctrl[1]};
         end else if (hit[2]) begin
            st_next.rdata[gpc_pkg::LVL_OUT_LO +: 2] = st_next.out_lvl;
            st_next.rdata[gpc_pkg::LVL_IN_LO +: 2]  = asserted;
         end
      end
   end

   // state register, control words start at their defaults
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg         <= '0;
         st_reg.ctrl[0] <= gpc_pkg::CTRL_RESET;
         st_reg.ctrl[1] <= gpc_pkg::CTRL_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign hrdata             = st_reg.rdata;
   assign pin5_pad_out       = st_reg.pad_out[0];
   assign pin5_pad_oe        = st_reg.pad_oe[0];
   assign pin5_pull_up_en    = st_reg.pull_up[0];
   assign pin5_pull_down_en  = st_reg.pull_dn[0];
   assign pin5_supply_select = st_reg.supply[0];
   assign pin5_edge_event    = st_reg.edge_ev[0];
   assign pin6_pad_out       = st_reg.pad_out[1];
   assign pin6_pad_oe        = st_reg.pad_oe[1];
   assign pin6_pull_up_en    = st_reg.pull_up[1];
   assign pin6_pull_down_en  = st_reg.pull_dn[1];
   assign pin6_supply_select = st_reg.supply[1];
   assign pin6_edge_event    = st_reg.edge_ev[1];

   // input functions; long and normal variants share one output
   assign power_onoff_req        = st_reg.fin[2];
   assign sleep_wake_req         = st_reg.fin[3] | st_reg.fin[4];
   assign sleep_req              = st_reg.fin[5];
   assign power_on_req           = st_reg.fin[6];
   assign watchdog_reset_req     = st_reg.fin[7];
   assign voltage_scale_select_1 = st_reg.fin[8];
   assign voltage_scale_select_2 = st_reg.fin[9];
   assign hw_enable_1            = st_reg.fin[10];
   assign hw_enable_2            = st_reg.fin[11];
   assign hw_control_1           = st_reg.fin[12] | st_reg.fin[14];
   assign hw_control_2           = st_reg.fin[13] | st_reg.fin[15];

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_wr_pin5;
      (acc && hwrite && hit[0]) ##1 1'b1;
   endsequence

   a_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
      s_wr_pin5 |=> st_reg.ctrl[0] ==
         ($past(hwdata[15:0]) & gpc_pkg::CTRL_WMASK))
      else $error("pin 5 control write did not land");

   a_ctrl_reset: assert property (@(posedge ref_clk) disable iff (reset)
      $past(reset) |-> st_reg.ctrl[0] == gpc_pkg::CTRL_RESET &&
                       st_reg.ctrl[1] == gpc_pkg::CTRL_RESET)
      else $error("control words not at default after reset");

   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (reset)
      ((st_reg.ctrl[0] | st_reg.ctrl[1]) & ~gpc_pkg::CTRL_WMASK)
         == 16'h0000)
      else $error("reserved control bits set");

   a_dir_input: assert property (@(posedge ref_clk) disable iff (reset)
      st_reg.ctrl[0][gpc_pkg::DIR_BIT] |=> !pin5_pad_oe)
      else $error("input pin is driven");

   a_tristate_off: assert property (@(posedge ref_clk) disable iff (reset)
      !st_reg.ctrl[1][gpc_pkg::ENA_BIT] |=> !pin6_pad_oe)
      else $error("disabled pin is driven");

   a_open_drain: assert property (@(posedge ref_clk) disable iff (reset)
      st_reg.ctrl[0][gpc_pkg::OD_BIT] |=> !pin5_pad_out)
      else $error("open-drain pin drives high");

   a_pull_decode: assert property (@(posedge ref_clk) disable iff (reset)
      st_reg.ctrl[0][gpc_pkg::PULL_HI:gpc_pkg::PULL_LO] == gpc_pkg::PULL_DOWN
      |=> pin5_pull_down_en && !pin5_pull_up_en)
      else $error("pull-down code not applied");

   a_supply_sel: assert property (@(posedge ref_clk) disable iff (reset)
      ##1 pin6_supply_select ==
         $past(st_reg.ctrl[1][gpc_pkg::SUPPLY_BIT]))
      else $error("supply select does not follow bit 11");

   a_edge_mode: assert property (@(posedge ref_clk) disable iff (reset)
      pin5_edge_event && !$past(st_reg.ctrl[0][gpc_pkg::MODE_BIT]) |->
         st_reg.prev_lvl[0] == $past(st_reg.ctrl[0][gpc_pkg::POL_BIT]))
      else $error("single-edge mode fired on the wrong edge");

   a_out_level: assert property (@(posedge ref_clk) disable iff (reset)
      st_reg.ctrl[0][gpc_pkg::ENA_BIT] && !st_reg.ctrl[0][gpc_pkg::DIR_BIT]
      && !st_reg.ctrl[0][gpc_pkg::OD_BIT]
      && st_reg.ctrl[0][gpc_pkg::FN_HI:0] == gpc_pkg::FO_LEVEL
      |=> pin5_pad_oe && pin5_pad_out == ($past(st_reg.out_lvl[0])
          ~^ $past(st_reg.ctrl[0][gpc_pkg::POL_BIT])))
      else $error("register level not driven with polarity");

   a_reserved_fn: assert property (@(posedge ref_clk) disable iff (reset)
      !st_reg.ctrl[0][gpc_pkg::DIR_BIT] && !st_reg.ctrl[0][gpc_pkg::OD_BIT]
      && st_reg.ctrl[0][gpc_pkg::FN_HI:0] >= gpc_pkg::FO_RSV_LO
      && st_reg.ctrl[0][gpc_pkg::FN_HI:0] <= gpc_pkg::FO_RSV_HI
      |=> pin5_pad_out == !$past(st_reg.ctrl[0][gpc_pkg::POL_BIT]))
      else $error("reserved output code not inactive");

   a_watchdog_in: assert property (@(posedge ref_clk) disable iff (reset)
      st_reg.ctrl[0][gpc_pkg::DIR_BIT] && st_reg.ctrl[0][gpc_pkg::ENA_BIT]
      && st_reg.ctrl[0][gpc_pkg::FN_HI:0] == gpc_pkg::FI_WDOG && asserted[0]
      |=> watchdog_reset_req)
      else $error("watchdog input not routed");

endmodule : gpc_top

`default_nettype wire

// ---- dv/gpc_pin_model.sv ----
// model of the system logic and the wire on one pin
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_model (
   input  wire logic ref_clk,  // system clock
   input  wire logic oe,       // block drives the wire
   input  wire logic out,      // block drive value
   input  wire logic pu,       // pull-up enabled
   input  wire logic pd,       // pull-down enabled
   input  wire logic ext_en,   // far side drives the wire
   input  wire logic ext_val,  // far side level
   output logic      pad       // resolved wire level
);
   logic last_reg = 1'b0; // last level, so a floating wire never holds it
   ////////////////////////////////////////////////////////////////////////
   // resolve drivers, then pulls; a floating wire flips every cycle
   always_comb begin
      if (oe) pad = out;
      else if (ext_en) pad = ext_val;
      else if (pu) pad = 1'b1;
      else if (pd) pad = 1'b0;
      else pad = ~last_reg;
   end
   always_ff @(posedge ref_clk) last_reg <= pad;
endmodule : gpc_pin_model
`default_nettype wire

// ---- dv/test_gpc_pin_config_control.sv ----
// self-checking bench for the two pin control registers
`timescale 1ns/1ps
`default_nettype none
module test_gpc_pin_config_control;
   logic ref_clk, hready, hreadyout, hresp, pin5_pad_in, pin6_pad_in;
   logic reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic ext_en = 1'b0, ext_val = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [11:0] src = 12'h000;
   logic pin5_pad_out, pin5_pad_oe, pin5_pull_up_en, pin5_pull_down_en;
   logic pin6_pad_out, pin6_pad_oe, pin6_pull_up_en, pin6_pull_down_en;
   logic pin5_supply_select, pin5_edge_event, pin6_supply_select;
   logic pin6_edge_event, osc_32k_clk, active_state, sleep_state;
   logic power_state_change, vscale_done_1, vscale_done_2, aux_reset;
   logic ext_power_enable_1, ext_power_enable_2, system_supply_good;
   logic converter_power_good, ext_power_clk_2m, power_onoff_req;
   logic sleep_wake_req, sleep_req, power_on_req, watchdog_reset_req;
   logic voltage_scale_select_1, voltage_scale_select_2, hw_enable_1;
   logic hw_enable_2, hw_control_1, hw_control_2;
   int   err_count = 0, tests_run = 0, n;
   localparam logic [31:0] A5 = {14'h0, gpc_pkg::PIN5_IDX, 2'h0};
   localparam logic [31:0] A6 = {14'h0, gpc_pkg::PIN6_IDX, 2'h0};
   localparam logic [31:0] AL = {14'h0, gpc_pkg::LEVEL_IDX, 2'h0};
   assign hready = hreadyout;
   assign {aux_reset, ext_power_clk_2m, converter_power_good} = src[11:9];
   assign {system_supply_good, ext_power_enable_2} = src[8:7];
   assign {ext_power_enable_1, vscale_done_2, vscale_done_1} = src[6:4];
   assign {power_state_change, sleep_state, active_state} = src[3:1];
   assign osc_32k_clk = src[0];
   gpc_top #(.NORMAL_DB_CYC(4), .LONG_DB_CYC(16)) uut (.*);
   gpc_pin_model m5 (.ref_clk(ref_clk), .oe(pin5_pad_oe), .out(pin5_pad_out),
      .pu(pin5_pull_up_en), .pd(pin5_pull_down_en), .ext_en(1'b0),
      .ext_val(1'b0), .pad(pin5_pad_in));
   gpc_pin_model m6 (.ref_clk(ref_clk), .oe(pin6_pad_oe), .out(pin6_pad_out),
      .pu(pin6_pull_up_en), .pd(pin6_pull_down_en), .ext_en(ext_en),
      .ext_val(ext_val), .pad(pin6_pad_in));
   ////////////////////////////////////////////////////////////////////////
   // compare, bus cycle and edge counting helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic cnt(output int c);
      c = 0;
      repeat (40) begin
         @(posedge ref_clk);
         c += int'(pin6_edge_event) + 16 * int'(pin5_edge_event);
      end
   endtask : cnt
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////
   // scenarios: defaults, reserved bits, output drive, input functions
   task automatic t_reset();
      bus(1'b0, A5, 32'h0);
      chk(rd, 32'h0000A400);
      bus(1'b0, A6, 32'h0);
      chk(rd, 32'h0000A400);
      chk({pin5_pull_down_en, pin5_pull_up_en, pin5_pad_oe}, 3'h4);
      chk({pin6_pull_down_en, pin6_pull_up_en, pin6_pad_oe}, 3'h4);
      chk({hresp, hreadyout, pin6_supply_select}, 3'h2);
   endtask : t_reset
   task automatic t_fields();
      bus(1'b1, A5, 32'hFFFFFFFF);
      bus(1'b0, A5, 32'h0);
      chk(rd, 32'h0000FE8F);
      repeat (3) @(posedge ref_clk);
      chk({pin5_pull_down_en, pin5_pull_up_en, pin5_supply_select},
          3'h1);
   endtask : t_fields
   task automatic t_out();
      logic [15:0] w [5] = '{16'h0480, 16'h0080, 16'h0680, 16'h048C, 16'h0485};
      logic [1:0]  e [5] = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h2};
      int          b;
      src <= 12'h100;
      bus(1'b1, AL, 32'h1);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, A5, {16'h0, w[i]});
         repeat (3) @(posedge ref_clk);
         chk({pin5_pad_oe, pin5_pad_out}, e[i]);
      end
      // each output code follows only its own source
      for (int k = 1; k < 16; k++) begin
         if (k < 5 || k > 7) begin
            b = (k < 5) ? k - 1 : k - 4;
            bus(1'b1, A5, {28'h0000048, 4'(k)});
            src <= 12'h001 << b;
            repeat (4) @(posedge ref_clk);
            chk({pin5_pad_oe, pin5_pad_out}, 2'h3);
            src <= ~(12'h001 << b);
            repeat (4) @(posedge ref_clk);
            chk({pin5_pad_oe, pin5_pad_out}, 2'h2);
         end
      end
      // second pin drives its own level bit
      bus(1'b1, AL, 32'h2);
      bus(1'b1, A6, 32'h0480);
      repeat (3) @(posedge ref_clk);
      chk({pin6_pad_oe, pin6_pad_out}, 2'h3);
   endtask : t_out
   task automatic t_in();
      logic [10:0] f [14] = '{11'h400, 11'h200, 11'h200, 11'h100, 11'h080,
                             11'h040, 11'h020, 11'h010, 11'h008, 11'h004,
                             11'h002, 11'h001, 11'h002, 11'h001};
      ext_en <= 1'b1;
      bus(1'b1, A6, 32'h8481);
      repeat (30) @(posedge ref_clk);
      ext_val <= 1'b1;
      cnt(n);
      chk(n, 1);
      bus(1'b0, AL, 32'h0);
      chk(rd[9], 1'b1);
      bus(1'b1, A6, 32'h8487);
      repeat (30) @(posedge ref_clk);
      chk(watchdog_reset_req, 1'b1);
      ext_val <= 1'b0;
      cnt(n);
      chk(n, 0);
      chk(watchdog_reset_req, 1'b0);
      // input codes 2 to 15 each raise only their own request
      ext_val <= 1'b1;
      repeat (12) @(posedge ref_clk);
      for (int k = 2; k < 16; k++) begin
         bus(1'b1, A6, {28'h0000848, 4'(k)});
         repeat (2) @(posedge ref_clk);
         chk({power_onoff_req, sleep_wake_req, sleep_req, power_on_req,
              watchdog_reset_req, voltage_scale_select_1,
              voltage_scale_select_2, hw_enable_1, hw_enable_2,
              hw_control_1, hw_control_2}, f[k-2]);
      end
      // long filter holds past the normal window; both-edge mode
      bus(1'b1, A6, 32'h9484);
      ext_val <= 1'b0;
      repeat (12) @(posedge ref_clk);
      chk(sleep_wake_req, 1'b1);
      cnt(n);
      chk(n, 1);
      chk(sleep_wake_req, 1'b0);
   endtask : t_in
   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and main sequence
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_fields();
      t_out();
      t_in();
      end_sim();
   end
endmodule : test_gpc_pin_config_control
`default_nettype wire
